// ---- src/jtap_tap.sv ----
// Function
// - Five high mode-select clocks force test reset
// - Mode select high holds test reset
// - Test reset disables all test logic
// - Idle held while mode select low
// - Data select, low mode select scans data
// - Instruction select, low starts instruction scan
// - Data capture parallel loads selected register
// - Data shift moves one bit outward
// - Data pause holds register unchanged
// - Data exit two: shift again or update
// - Data update loads parallel output latch
// - Output latches steady during shifting
// - Instruction capture loads capture value
// - Instruction shift moves one bit outward
// - Instruction pause holds instruction register
// - Instruction exit two: shift or update
// - Instruction update sets active instruction
// - Active instruction selects operation and register
// - Instruction path at least two cells
// - Bypass and boundary-scan registers exist
// - Bypass is one bit, passes through
module jtap_tap (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic tck,
    input wire logic trst_b,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [jtap_pkg::BSR_LEN-1:0] sys_pins_in,
    output jtap_pkg::jtap_bsr_s bsr_out,
    output logic [jtap_pkg::IR_LEN-1:0] insn_active,
    output logic tap_in_reset
);
    import jtap_pkg::*;

    // ----------------------------------------------------------------------
    // State machine on the test clock
    // ----------------------------------------------------------------------
    jtap_state_e state;
    jtap_state_e next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_RESET: next_state = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
        endcase
    end

    always_ff @(posedge tck or negedge trst_b) begin
        if (!trst_b) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------------
    // State decode
    // ----------------------------------------------------------------------
    function automatic jtap_ctl_s decode_ctl(input jtap_state_e s);
        jtap_ctl_s c;
        c.cap_dr = (s == ST_CAP_DR);
        c.shift_dr = (s == ST_SHIFT_DR);
        c.upd_dr = (s == ST_UPD_DR);
        c.cap_ir = (s == ST_CAP_IR);
        c.shift_ir = (s == ST_SHIFT_IR);
        c.upd_ir = (s == ST_UPD_IR);
        c.in_reset = (s == ST_RESET);
        return c;
    endfunction

    jtap_ctl_s ctl;
    assign ctl = decode_ctl(state);

    // ----------------------------------------------------------------------
    // Instruction register
    // ----------------------------------------------------------------------
    logic [IR_LEN-1:0] ir_shift;
    logic [IR_LEN-1:0] ir_hold;

    always_ff @(posedge tck or negedge trst_b) begin
        if (!trst_b) begin
            ir_shift <= IR_RESET_VAL;
        end else if (ctl.in_reset) begin
            ir_shift <= IR_RESET_VAL;
        end else if (ctl.cap_ir) begin
            ir_shift <= IR_CAPTURE_VAL;
        end else if (ctl.shift_ir) begin
            ir_shift <= {tdi, ir_shift[IR_LEN-1:1]};
        end
    end
    // Pause and exit states keep ir_shift untouched

    // Update on falling edge keeps the latch clear of shifting edges
    always_ff @(negedge tck or negedge trst_b) begin
        if (!trst_b) begin
            ir_hold <= IR_RESET_VAL;
        end else if (ctl.in_reset) begin
            ir_hold <= IR_RESET_VAL;
        end else if (ctl.upd_ir) begin
            ir_hold <= ir_shift;
        end
    end

    // ----------------------------------------------------------------------
    // Data register selection
    // ----------------------------------------------------------------------
    function automatic logic sel_bsr(input logic [IR_LEN-1:0] insn);
        sel_bsr = (insn == INSN_EXTEST) || (insn == INSN_SAMPLE);
    endfunction

    wire use_bsr = sel_bsr(ir_hold);
    wire use_bypass = !use_bsr;

    // ----------------------------------------------------------------------
    // Bypass and boundary-scan registers
    // ----------------------------------------------------------------------
    logic bypass_bit;
    logic [BSR_LEN-1:0] bsr_shift;
    logic [BSR_LEN-1:0] bsr_hold;

    always_ff @(posedge tck or negedge trst_b) begin
        if (!trst_b) begin
            bypass_bit <= 1'b0;
        end else if (ctl.in_reset) begin
            bypass_bit <= 1'b0;
        end else if (ctl.cap_dr && use_bypass) begin
            bypass_bit <= 1'b0;
        end else if (ctl.shift_dr && use_bypass) begin
            bypass_bit <= tdi;
        end
    end

    always_ff @(posedge tck or negedge trst_b) begin
        if (!trst_b) begin
            bsr_shift <= BSR_RESET_VAL;
        end else if (ctl.in_reset) begin
            bsr_shift <= BSR_RESET_VAL;
        end else if (ctl.cap_dr && use_bsr) begin
            bsr_shift <= sys_pins_in;
        end else if (ctl.shift_dr && use_bsr) begin
            bsr_shift <= {tdi, bsr_shift[BSR_LEN-1:1]};
        end
    end
    // No load in pause or exit states

    always_ff @(negedge tck or negedge trst_b) begin
        if (!trst_b) begin
            bsr_hold <= BSR_RESET_VAL;
        end else if (ctl.upd_dr && use_bsr) begin
            bsr_hold <= bsr_shift;
        end
    end

    // ----------------------------------------------------------------------
    // Serial output on the falling edge
    // ----------------------------------------------------------------------
    wire dr_bit = use_bsr ? bsr_shift[0] : bypass_bit;
    wire next_tdo = ctl.shift_ir ? ir_shift[0] : dr_bit;
    wire next_tdo_oe = ctl.shift_ir || ctl.shift_dr;
    logic tdo_q;
    logic tdo_oe_q;

    always_ff @(negedge tck or negedge trst_b) begin
        if (!trst_b) begin
            tdo_q <= 1'b0;
        end else begin
            tdo_q <= next_tdo;
        end
    end

    // Enable moves on the same edge as the data, so no stale bit shows
    always_ff @(negedge tck or negedge trst_b) begin
        if (!trst_b) begin
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_oe_q <= next_tdo_oe;
        end
    end

    assign tdo = tdo_q;
    assign tdo_oe = tdo_oe_q;

    // ----------------------------------------------------------------------
    // Test clock side of the crossing
    // ----------------------------------------------------------------------
    // Level shown to the core: pins driven by the boundary register
    logic test_mode_tck;
    wire next_test_mode = (ir_hold == INSN_EXTEST) && !ctl.in_reset;

    always_ff @(negedge tck or negedge trst_b) begin
        if (!trst_b) begin
            test_mode_tck <= 1'b0;
        end else begin
            test_mode_tck <= next_test_mode;
        end
    end

    // Level shown to the core: controller in or entering test reset
    logic reset_tck;
    wire next_reset = (next_state == ST_RESET);

    always_ff @(posedge tck or negedge trst_b) begin
        if (!trst_b) begin
            reset_tck <= 1'b1;
        end else begin
            reset_tck <= next_reset;
        end
    end

    // Flips once per latch update. The latched words then stay still
    // for several test clocks, so the core copies each word whole once
    // the flip has crossed, free of bit-by-bit skew
    logic upd_tgl;
    wire upd_any = ctl.upd_ir || (ctl.upd_dr && use_bsr);
    wire next_upd_tgl = upd_tgl ^ upd_any;

    always_ff @(negedge tck or negedge trst_b) begin
        if (!trst_b) begin
            upd_tgl <= 1'b0;
        end else begin
            upd_tgl <= next_upd_tgl;
        end
    end

    // ----------------------------------------------------------------------
    // Core clock side of the crossing
    // ----------------------------------------------------------------------
    logic test_mode_core;
    logic reset_core;
    logic upd_tgl_core;
    logic upd_tgl_seen;

    jtap_sync u_sync_mode (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .d(test_mode_tck),
        .q(test_mode_core)
    );

    jtap_sync u_sync_rst (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .d(reset_tck),
        .q(reset_core)
    );

    jtap_sync u_sync_upd (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .d(upd_tgl),
        .q(upd_tgl_core)
    );

    // A new update has crossed when the synced flip moves
    wire upd_seen = upd_tgl_core ^ upd_tgl_seen;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            upd_tgl_seen <= 1'b0;
        end else begin
            upd_tgl_seen <= upd_tgl_core;
        end
    end

    // ----------------------------------------------------------------------
    // Core outputs
    // ----------------------------------------------------------------------
    wire next_mode_out = test_mode_core && !reset_core;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bsr_out <= '0;
        end else begin
            bsr_out.test_mode <= next_mode_out;
            if (upd_seen) begin
                bsr_out.pins <= bsr_hold;
            end
        end
    end

    // Test reset wins over an update that crosses at the same time
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            insn_active <= IR_RESET_VAL;
        end else if (reset_core) begin
            insn_active <= IR_RESET_VAL;
        end else if (upd_seen) begin
            insn_active <= ir_hold;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tap_in_reset <= 1'b1;
        end else begin
            tap_in_reset <= reset_core;
        end
    end
endmodule

// ---- src/jtap_pkg.sv ----
package jtap_pkg;

    // ----------------------------------------------------------------------
    // Widths and encodings
    // ----------------------------------------------------------------------
    localparam int IR_LEN = 4;
    localparam int BSR_LEN = 8;
    localparam int RESET_TMS_CYCLES = 5;

    localparam logic [IR_LEN-1:0] INSN_EXTEST = 4'h0;
    localparam logic [IR_LEN-1:0] INSN_SAMPLE = 4'h1;
    localparam logic [IR_LEN-1:0] INSN_BYPASS = 4'hF;
    localparam logic [IR_LEN-1:0] IR_RESET_VAL = 4'hF;
    localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 4'h1;
    localparam logic [BSR_LEN-1:0] BSR_RESET_VAL = 8'h00;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
        ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } jtap_state_e;

    typedef struct packed {
        logic cap_dr;
        logic shift_dr;
        logic upd_dr;
        logic cap_ir;
        logic shift_ir;
        logic upd_ir;
        logic in_reset;
    } jtap_ctl_s;

    typedef struct packed {
        logic test_mode;
        logic [BSR_LEN-1:0] pins;
    } jtap_bsr_s;

endpackage

// ---- src/jtap_sync.sv ----
// Three-stage synchroniser, change taken once stages two and three agree
module jtap_sync (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic d,
    output logic q
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q <= 1'b0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q <= s3;
            end
        end
    end
endmodule

// ---- testbench/jtap_tap_checker.sv ----
module jtap_checker (
    input logic core_clk,
    input logic rst_b,
    input logic tck,
    input logic trst_b,
    input logic tms,
    input logic tdo,
    input logic tdo_oe,
    input jtap_pkg::jtap_bsr_s bsr_out,
    input logic [jtap_pkg::IR_LEN-1:0] insn_active,
    input logic tap_in_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    import jtap_pkg::*;
    logic [2:0] hi;
    wire rst_st = hi == 3'h5;
    // Five highs in a row, or a test reset, mean the reset state
    always_ff @(posedge tck or negedge trst_b) begin
        if (!trst_b) begin
            hi <= 3'h5;
        end else begin
            hi <= !tms ? 3'h0 : (rst_st ? 3'h5 : hi + 3'h1);
        end
    end
    a_reset_quiet: assert property (@(posedge tck)
        disable iff (!trst_b) rst_st |-> !tdo_oe) else $error("oe in reset");
    a_idle_holds: assert property (@(posedge tck)
        disable iff (!trst_b) (rst_st && !tms) ##1 !tms |=> !tdo_oe)
        else $error("idle left");
    a_dr_start: assert property (@(posedge tck)
        disable iff (!trst_b) (rst_st && !tms) ##1 tms ##1 !tms[*2]
        |=> tdo_oe) else $error("no data shift");
    a_ir_capture: assert property (@(posedge tck)
        disable iff (!trst_b) (rst_st && !tms) ##1 tms[*2] ##1 !tms[*2]
        |=> tdo_oe && tdo) else $error("no insn shift");
    a_shift_holds: assert property (@(posedge tck)
        disable iff (!trst_b) tdo_oe && !tms |=> tdo_oe)
        else $error("shift left");
    a_pause_quiet: assert property (@(posedge tck)
        disable iff (!trst_b) tdo_oe && tms ##1 !tms |=> !tdo_oe)
        else $error("oe in pause");
    a_exit_resume: assert property (@(posedge tck)
        disable iff (!trst_b) tdo_oe && tms ##1 !tms[*2] ##1 tms ##1 !tms
        |=> tdo_oe) else $error("no resume");
    a_out_fall: assert property (@(posedge core_clk)
        disable iff (!rst_b) tck |-> $stable({tdo, tdo_oe}))
        else $error("tdo moved while tck high");
    a_latch_steady: assert property (@(posedge core_clk)
        disable iff (!rst_b) tdo_oe[*8] |-> $stable(insn_active)
        && $stable(bsr_out)) else $error("latch moved in shift");
    a_reset_off: assert property (@(posedge core_clk)
        disable iff (!rst_b) tap_in_reset[*8] |-> !bsr_out.test_mode)
        else $error("test mode in reset");
    cover property (@(posedge tck) tdo_oe && tms ##1 !tms[*2] ##1 tms);
    cover property (@(posedge tck) rst_st && !tms ##1 tms);
    cover property (@(posedge core_clk) $fell(tap_in_reset));
endmodule

bind jtap_tap jtap_checker chk (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .tck(tck),
    .trst_b(trst_b),
    .tms(tms),
    .tdo(tdo),
    .tdo_oe(tdo_oe),
    .bsr_out(bsr_out),
    .insn_active(insn_active),
    .tap_in_reset(tap_in_reset)
);

// ---- testbench/jtap_host.sv ----
module jtap_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_b,
    input wire logic tdo_line
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_b = 1'b0;
    end
    // Test clock stands low between steps
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #24 tck = 1'b1;
        o = tdo_line;
        #24 tck = 1'b0;
    endtask
    task automatic go(input logic m);
        logic o;
        step(m, ~tdi, o);
    endtask
    // Scan from idle with a pause after the second bit
    task automatic scan(input logic ir, input logic [7:0] din, input int n,
        output logic [7:0] dout);
        logic o;
        dout = 8'h00;
        go(1'b1);
        if (ir) begin
            go(1'b1);
        end
        go(1'b0);
        go(1'b0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1 || i == 1, din[i], o);
            dout[i] = o;
            if (i == 1) begin
                go(1'b0);
                go(1'b0);
                go(1'b1);
                go(1'b0);
            end
        end
        go(1'b1);
        go(1'b0);
    endtask
endmodule

// ---- testbench/jtap_tap_tb.sv ----
module jtap_tap_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import jtap_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b;
    logic [7:0] sys_pins_in;
    logic tck, tms, tdi, trst_b, tdo, tdo_oe, tap_in_reset;
    logic [3:0] insn_active;
    jtap_bsr_s bsr_out;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    wire tdo_line = tdo_oe ? tdo : 1'b1;
    always #2.5 core_clk = ~core_clk;
    jtap_tap dut (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .tck(tck),
        .trst_b(trst_b),
        .tms(tms),
        .tdi(tdi),
        .tdo(tdo),
        .tdo_oe(tdo_oe),
        .sys_pins_in(sys_pins_in),
        .bsr_out(bsr_out),
        .insn_active(insn_active),
        .tap_in_reset(tap_in_reset)
    );
    jtap_host host (
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .trst_b(trst_b),
        .tdo_line(tdo_line)
    );
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic [7:0] exp_dr(logic [3:0] ir, logic [7:0] d,
        logic [7:0] pins);
        return (ir == INSN_EXTEST || ir == INSN_SAMPLE) ? pins : {d[6:0], 1'b0};
    endfunction
    task automatic scan_ir(input logic [3:0] ir);
        logic [7:0] dout;
        host.scan(1'b1, {4'h0, ir}, 4, dout);
        check(dout[3:0], IR_CAPTURE_VAL);
        repeat (8) @(negedge core_clk);
        check(insn_active, ir);
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 10000) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        logic [7:0] din, dout, lat;
        logic [3:0] ir;
        rst_b = 1'b0;
        sys_pins_in = 8'h00;
        lat = BSR_RESET_VAL;
        void'($urandom(12990));
        repeat (8) @(negedge core_clk);
        rst_b = 1'b1;
        host.trst_b = 1'b1;
        repeat (8) @(negedge core_clk);
        check(insn_active, IR_RESET_VAL);
        check(bsr_out, BSR_RESET_VAL);
        host.go(1'b0);
        host.go(1'b0);
        for (int i = 0; i < 8; i++) begin
            ir = i == 0 ? INSN_SAMPLE : i == 1 ? INSN_EXTEST :
                i == 2 ? INSN_BYPASS : 4'($urandom);
            scan_ir(ir);
            din = 8'($urandom);
            sys_pins_in = 8'($urandom);
            repeat (8) @(negedge core_clk);
            host.scan(1'b0, din, 8, dout);
            check(dout, exp_dr(ir, din, sys_pins_in));
            lat = (ir == INSN_EXTEST || ir == INSN_SAMPLE) ? din : lat;
            repeat (8) @(negedge core_clk);
            check(bsr_out, {ir == INSN_EXTEST, lat});
        end
        scan_ir(INSN_EXTEST);
        host.go(1'b1);
        host.go(1'b0);
        host.go(1'b0);
        repeat (5) host.go(1'b1);
        repeat (8) @(negedge core_clk);
        check(tap_in_reset, 1'b1);
        check(insn_active, IR_RESET_VAL);
        check(bsr_out.test_mode, 1'b0);
        repeat (3) host.go(1'b1);
        check(tap_in_reset, 1'b1);
        host.go(1'b0);
        scan_ir(INSN_SAMPLE);
        host.go(1'b1);
        host.go(1'b0);
        host.go(1'b0);
        @(negedge core_clk);
        host.trst_b = 1'b0;
        repeat (2) @(negedge core_clk);
        check(tdo_oe, 1'b0);
        host.trst_b = 1'b1;
        repeat (8) @(negedge core_clk);
        check(insn_active, IR_RESET_VAL);
        host.go(1'b0);
        host.scan(1'b0, din, 8, dout);
        check(dout, exp_dr(INSN_BYPASS, din, 8'h00));
        end_of_test();
    end
endmodule
